/* verilog/isu_top.sv */
// Upper interrupt status bits with mask, watchdog and AHB-Lite register slave.
//
// Overview of operation
// [R1] Bit 28 follows OTP write-done level.
// [R2] Bit 26 latches transmit idle-entry pulse.
// [R3] Bit 25 latches transmit idle-exit pulse.
// [R4] Bit 24 latches receive idle-entry pulse.
// [R5] Energy bits held zero while saving disabled.
// [R6] Bit 23 latches 8 ms watchdog expiry.
// [R7] Watchdog expiry releases MAC reset immediately.
// [R8] Bit 22 follows receive FIFO overflow level.
// [R9] Drop receive writes while overflow active.
// [R10] Bit 21 follows transmit error level.
// [R11] Bit 20 follows USB event level.
// [R12] Bit 19 while either transmit-off bit set.
// [R13] Bit 18 while either receive-off bit set.
// [R14] Bit 17 follows PHY interrupt level.
// [R15] Bit 16 latches data port done pulse.
// [R16] Write one clears; reserved bits read zero.
// [R17] Pulses latch; levels reassert after clearing.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module isu_top
    import isu_pkg::*;
#(
    parameter int WATCHDOG_CYCLES = ISU_WATCHDOG_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event sources from other units on the same clock.
    input wire logic otp_done_level,
    input wire logic tx_idle_entry_pulse,
    input wire logic tx_idle_exit_pulse,
    input wire logic rx_idle_entry_pulse,
    input wire logic rx_overflow_level,
    input wire logic tx_error_level,
    input wire logic usb_event_level,
    input wire logic fifo_tx_off,
    input wire logic mac_transmit_reg_off,
    input wire logic fifo_rx_off,
    input wire logic mac_receive_reg_off,
    input wire logic phy_event_level,
    input wire logic dp_done_pulse,
    // MAC reset handling; the PHY clock present flag comes from another domain.
    input wire logic mac_reset_req,
    input wire logic phy_clk_present,
    output logic mac_reset,
    // Receive data path gating.
    input wire logic rx_write_req,
    output logic rx_write_en,
    // Interrupt and energy enable outputs.
    output logic irq,
    output logic energy_saving_enable
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************

    // Data phase state captured at the address phase.
    logic wr_pend_q;
    logic rd_pend_q;
    logic [11:0] addr_q;
    // Register contents.
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] mask_q;
    logic energy_q;

    // An address phase is taken when selected, active and the bus is ready.
    logic take;
    assign take = hsel && hready && (htrans == ISU_HTRANS_NONSEQ || htrans == ISU_HTRANS_SEQ);

    // Capture the address phase; every transfer completes with no wait state.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // The slave never stalls and always answers OKAY.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= ISU_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= ISU_HRESP_OKAY;
        end
    end

    // Read data is registered in the address phase so it stands from a flop in the data phase.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            unique case (haddr)
                ISU_STATUS_OFFSET: begin
                    hrdata <= status_q & ISU_STATUS_IMPL; // R16
                end
                ISU_MASK_OFFSET: begin
                    hrdata <= mask_q;
                end
                ISU_CONTROL_OFFSET: begin
                    hrdata <= {31'h0000_0000, energy_q};
                end
                default: begin
                    // Unmapped addresses read as zero.
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Write strobes decoded from the captured address.
    logic wr_status;
    logic wr_mask;
    logic wr_control;
    assign wr_status = wr_pend_q && addr_q == ISU_STATUS_OFFSET;
    assign wr_mask = wr_pend_q && addr_q == ISU_MASK_OFFSET;
    assign wr_control = wr_pend_q && addr_q == ISU_CONTROL_OFFSET;

    // Mask register; only implemented bits can be enabled.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_q <= ISU_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= hwdata & ISU_STATUS_IMPL;
        end
    end

    // Control register holding the energy saving enable.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            energy_q <= ISU_ENERGY_RESET;
        end else if (wr_control) begin
            energy_q <= hwdata[ISU_BIT_ENERGY_EN];
        end
    end

    // ****************************************************************
    // MAC reset watchdog
    // ****************************************************************

    // The presence flag is from the PHY clock domain, so it is synchronised first.
    logic phy_sync1_q;
    logic phy_sync2_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phy_sync1_q <= 1'b0;
            phy_sync2_q <= 1'b0;
        end else begin
            phy_sync1_q <= phy_clk_present;
            phy_sync2_q <= phy_sync1_q;
        end
    end

    // Watchdog counter runs while the MAC is held in reset without PHY clocks.
    logic [$clog2(WATCHDOG_CYCLES+1)-1:0] wd_cnt_q;
    logic wd_expire_q;
    logic wd_fired_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !mac_reset_req || phy_sync2_q) begin
            wd_cnt_q <= '0;
            wd_expire_q <= 1'b0;
            wd_fired_q <= 1'b0;
        end else if (!wd_fired_q) begin
            if (wd_cnt_q == WATCHDOG_CYCLES[$bits(wd_cnt_q)-1:0] - 1'b1) begin
                // A single pulse marks the expiry; the counter then rests.
                wd_expire_q <= 1'b1; // R6
                wd_fired_q <= 1'b1;
            end else begin
                wd_cnt_q <= wd_cnt_q + 1'b1;
            end
        end else begin
            wd_expire_q <= 1'b0;
        end
    end

    // The MAC reset follows the request but drops once the watchdog has fired, without PHY clocks.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mac_reset <= 1'b1;
        end else begin
            mac_reset <= mac_reset_req && !wd_fired_q && !(wd_cnt_q == WATCHDOG_CYCLES[$bits(wd_cnt_q)-1:0] - 1'b1); // R7
        end
    end

    // ****************************************************************
    // Receive write gating
    // ****************************************************************

    // While the FIFO overflow level stands, new receive data is discarded.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_write_en <= 1'b0;
        end else begin
            rx_write_en <= rx_write_req && !rx_overflow_level; // R9
        end
    end

    // ****************************************************************
    // Status bits
    // ****************************************************************

    // Gathered event sources, placed at their bit positions.
    logic [31:0] src;
    always_comb begin
        src = 32'h0000_0000;
        src[ISU_BIT_OTP_DONE] = otp_done_level; // R1
        src[ISU_BIT_TX_IDLE_ENTRY] = tx_idle_entry_pulse; // R2
        src[ISU_BIT_TX_IDLE_EXIT] = tx_idle_exit_pulse; // R3
        src[ISU_BIT_RX_IDLE_ENTRY] = rx_idle_entry_pulse; // R4
        src[ISU_BIT_MAC_WATCHDOG] = wd_expire_q; // R6
        src[ISU_BIT_RX_OVERFLOW] = rx_overflow_level; // R8
        src[ISU_BIT_TX_ERROR] = tx_error_level; // R10
        src[ISU_BIT_USB_EVENT] = usb_event_level; // R11
        src[ISU_BIT_TX_OFF] = fifo_tx_off || mac_transmit_reg_off; // R12
        src[ISU_BIT_RX_OFF] = fifo_rx_off || mac_receive_reg_off; // R13
        src[ISU_BIT_PHY_EVENT] = phy_event_level; // R14
        src[ISU_BIT_DP_DONE] = dp_done_pulse; // R15
    end

    // Next status: write-one clears, and a source in the same cycle wins over the clear.
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_d & ~hwdata; // R16
        end
        // Level sources keep setting the bit, so a cleared bit comes straight back.
        status_d = (status_d | src) & ISU_STATUS_IMPL; // R17
        if (!energy_q) begin
            status_d = status_d & ~ISU_ENERGY_BITS; // R5
        end
    end

    // Status register update.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_q <= ISU_STATUS_RESET; // R16
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt output and energy enable, both from flops.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
            energy_saving_enable <= ISU_ENERGY_RESET;
        end else begin
            irq <= |(status_d & mask_q);
            energy_saving_enable <= energy_q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Pulse in a cycle with no write to the status register.
    sequence s_dp_pulse;
        dp_done_pulse && !wr_status;
    endsequence

    a_pulse_latch_hold: assert property (s_dp_pulse ##1 !wr_status[*3] |-> status_q[ISU_BIT_DP_DONE][*3]) // R17
        else $error("Data port done bit did not stay latched.");
    a_level_reassert: assert property (phy_event_level |=> status_q[ISU_BIT_PHY_EVENT]) // R14
        else $error("PHY event bit not set while source high.");
    a_energy_held_low: assert property ($past(!energy_q) |-> (status_q & ISU_ENERGY_BITS) == 32'h0000_0000) // R5
        else $error("Energy bit set while energy saving off.");
    a_reserved_zero: assert property ((status_q & ~ISU_STATUS_IMPL) == 32'h0000_0000) // R16
        else $error("Reserved status bit set.");
    a_w1c_clears: assert property (wr_status && hwdata[ISU_BIT_TX_ERROR] && !tx_error_level
        |=> !status_q[ISU_BIT_TX_ERROR]) // R16
        else $error("Write one did not clear transmit error bit.");
    a_tx_off_or: assert property ((fifo_tx_off || mac_transmit_reg_off) |=> status_q[ISU_BIT_TX_OFF]) // R12
        else $error("Transmit off bit missing.");
    a_rx_off_or: assert property ((fifo_rx_off || mac_receive_reg_off) |=> status_q[ISU_BIT_RX_OFF]) // R13
        else $error("Receive off bit missing.");
    a_overflow_drop: assert property (rx_overflow_level |=> !rx_write_en) // R9
        else $error("Receive write passed during overflow.");
    a_watchdog_flag: assert property (wd_expire_q |=> status_q[ISU_BIT_MAC_WATCHDOG] && !mac_reset) // R7
        else $error("Watchdog expiry did not flag and release reset.");
    a_usb_level: assert property (usb_event_level |=> status_q[ISU_BIT_USB_EVENT]) // R11
        else $error("USB event bit missing.");

    // The interrupt line is computed from the next status, so it lines up with the status register.
    // The mask used is the one that stood in the previous cycle, hence the sampled past value.
    a_irq_level: assert property (irq == |(status_q & $past(mask_q))) // R16
        else $error("Interrupt line disagrees with masked status.");

    // The watchdog marks its expiry with exactly one cycle, so bit 23 is set once per timeout.
    a_wd_single_pulse: assert property (wd_expire_q |=> !wd_expire_q) // R6
        else $error("Watchdog expiry lasted more than one cycle.");

    // Once the watchdog has fired, the MAC must stay out of reset while the request is held.
    a_wd_release_hold: assert property (wd_fired_q |-> !mac_reset) // R7
        else $error("MAC reset asserted after watchdog expiry.");

    // The slave never inserts wait states and never signals an error.
    a_bus_no_wait: assert property (hreadyout && hresp == ISU_HRESP_OKAY) // R16
        else $error("Bus slave stalled or answered with an error.");

    // A data port pulse is seen in the status register one edge later.
    a_pulse_sets: assert property (dp_done_pulse |=> status_q[ISU_BIT_DP_DONE]) // R15
        else $error("Data port done pulse not latched.");

    // The OTP level keeps the bit set even through a clear.
    a_otp_level: assert property (otp_done_level |=> status_q[ISU_BIT_OTP_DONE]) // R1
        else $error("OTP done bit missing while source high.");

endmodule

/* verilog/isu_pkg.sv */
// Package with offsets, field positions and timing constants of the interrupt status block.
package isu_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************

    // Byte address of the interrupt status register.
    localparam logic [11:0] ISU_STATUS_OFFSET = 12'h00c;
    // Byte address of the interrupt mask register.
    localparam logic [11:0] ISU_MASK_OFFSET = 12'h010;
    // Byte address of the control register (energy saving enable).
    localparam logic [11:0] ISU_CONTROL_OFFSET = 12'h014;

    // ****************************************************************
    // Field positions
    // ****************************************************************

    // Status bit positions inside the word.
    localparam int ISU_BIT_OTP_DONE = 28;
    localparam int ISU_BIT_TX_IDLE_ENTRY = 26;
    localparam int ISU_BIT_TX_IDLE_EXIT = 25;
    localparam int ISU_BIT_RX_IDLE_ENTRY = 24;
    localparam int ISU_BIT_MAC_WATCHDOG = 23;
    localparam int ISU_BIT_RX_OVERFLOW = 22;
    localparam int ISU_BIT_TX_ERROR = 21;
    localparam int ISU_BIT_USB_EVENT = 20;
    localparam int ISU_BIT_TX_OFF = 19;
    localparam int ISU_BIT_RX_OFF = 18;
    localparam int ISU_BIT_PHY_EVENT = 17;
    localparam int ISU_BIT_DP_DONE = 16;
    // Bit of the control register that enables energy saving.
    localparam int ISU_BIT_ENERGY_EN = 0;

    // Implemented status bits; the rest read as zero.
    localparam logic [31:0] ISU_STATUS_IMPL = 32'h17ff_0000;
    // Sources that are pulses; the others are levels.
    localparam logic [31:0] ISU_PULSE_SRC = 32'h0781_0000;
    // Energy saving bits held low while energy saving is off.
    localparam logic [31:0] ISU_ENERGY_BITS = 32'h0700_0000;

    // ****************************************************************
    // Reset values
    // ****************************************************************

    localparam logic [31:0] ISU_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ISU_MASK_RESET = 32'h0000_0000;
    localparam logic ISU_ENERGY_RESET = 1'b0;

    // ****************************************************************
    // Timing
    // ****************************************************************

    // Clock rate in kHz and the watchdog time in ms.
    localparam int ISU_CLK_KHZ = 20000;
    localparam int ISU_WATCHDOG_MS = 8;
    // Watchdog length in clock cycles.
    localparam int ISU_WATCHDOG_CYCLES = ISU_WATCHDOG_MS * ISU_CLK_KHZ;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************

    localparam logic [1:0] ISU_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ISU_HTRANS_SEQ = 2'h3;
    localparam logic ISU_HRESP_OKAY = 1'b0;

endpackage

/* tb/isu_top_bench.sv */
// Self-checking bench for the upper interrupt status bits block.
`timescale 1ns/1ps

module isu_top_bench;
    import isu_pkg::*;

    // ****************************************************************
    // Signals and design instance
    // ****************************************************************

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [12:0] src = 13'h0000; // Event sources, one per table entry.
    logic mac_reset_req = 1'b1;
    logic phy_clk_present = 1'b0;
    logic mac_reset;
    logic rx_write_req = 1'b0;
    logic rx_write_en;
    logic irq;
    logic energy_saving_enable;
    logic rd_dp = 1'b0; // A read is in its data phase.
    logic [31:0] exp_q[$]; // Expected read data, oldest first.
    logic [31:0] rnd = 32'h0000_004b; // Xorshift state.
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int cnt;
    // Status bit of each source and whether the source is a pulse.
    int bitpos[13] = '{28, 26, 25, 24, 22, 21, 20, 19, 19, 18, 18, 17, 16};
    logic [12:0] is_pulse = 13'h100e;

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    isu_top #(.WATCHDOG_CYCLES(20)) i_isu_top (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .otp_done_level(src[0]), .tx_idle_entry_pulse(src[1]),
        .tx_idle_exit_pulse(src[2]), .rx_idle_entry_pulse(src[3]), .rx_overflow_level(src[4]),
        .tx_error_level(src[5]), .usb_event_level(src[6]), .fifo_tx_off(src[7]), .mac_transmit_reg_off(src[8]),
        .fifo_rx_off(src[9]), .mac_receive_reg_off(src[10]), .phy_event_level(src[11]), .dp_done_pulse(src[12]),
        .mac_reset_req(mac_reset_req), .phy_clk_present(phy_clk_present), .mac_reset(mac_reset),
        .rx_write_req(rx_write_req), .rx_write_en(rx_write_en), .irq(irq),
        .energy_saving_enable(energy_saving_enable));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************

    // Compares one value and counts the result.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Next pseudo-random word; the state never reaches zero.
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // One single AHB-Lite transfer; a read notes its expected data.
    task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ISU_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        if (!wr) begin
            exp_q.push_back(d);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~d; // A read leaves no useful value on the write bus.
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    // Raises one source for a single cycle.
    task automatic strobe(input int i);
        src[i] <= 1'b1;
        @(posedge ref_clk);
        src[i] <= 1'b0;
    endtask

    // Takes the oldest note whenever read data is due.
    always @(posedge ref_clk) begin
        if (rd_dp && hready === 1'b1) begin
            check("hrdata", exp_q.pop_front(), hrdata);
            check("hresp", ISU_HRESP_OKAY, hresp);
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end

    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************

    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values; the watchdog runs because no PHY clock is present.
        bus_xfer(1'b0, ISU_STATUS_OFFSET, ISU_STATUS_RESET);
        bus_xfer(1'b0, ISU_MASK_OFFSET, ISU_MASK_RESET);
        bus_xfer(1'b0, ISU_CONTROL_OFFSET, {31'h0, ISU_ENERGY_RESET});
        cnt = 0;
        while (mac_reset !== 1'b0 && cnt < 200) begin
            @(posedge ref_clk);
            cnt++;
        end
        mac_reset_req <= 1'b0;
        check("watchdog", 32'h1, {31'h0, cnt >= 7 && cnt <= 16});
        bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h1 << ISU_BIT_MAC_WATCHDOG);
        bus_xfer(1'b1, ISU_STATUS_OFFSET, 32'h1 << ISU_BIT_MAC_WATCHDOG);
        // Each source with energy saving on; levels are held through a clear.
        bus_xfer(1'b1, ISU_CONTROL_OFFSET, 32'h0000_0001);
        // The control bit lands at the data edge and the output copy follows one edge later.
        repeat (2) @(posedge ref_clk);
        check("energy", 32'h1, {31'h0, energy_saving_enable});
        for (int i = 0; i < 13; i++) begin
            strobe(i);
            bus_xfer(1'b1, ISU_STATUS_OFFSET, ~(32'h1 << bitpos[i]));
            bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h1 << bitpos[i]);
            if (!is_pulse[i]) begin
                src[i] <= 1'b1;
                bus_xfer(1'b1, ISU_STATUS_OFFSET, 32'h1 << bitpos[i]);
                bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h1 << bitpos[i]);
                src[i] <= 1'b0;
            end
            bus_xfer(1'b1, ISU_STATUS_OFFSET, 32'h1 << bitpos[i]);
            bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h0000_0000);
        end
        // Energy events are held off while saving is disabled.
        bus_xfer(1'b1, ISU_CONTROL_OFFSET, 32'h0000_0000);
        strobe(1);
        strobe(2);
        strobe(3);
        bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h0000_0000);
        // Random mask read back, then one masked and one unmasked event.
        rnd = xorshift(rnd);
        bus_xfer(1'b1, ISU_MASK_OFFSET, rnd & ISU_STATUS_IMPL);
        bus_xfer(1'b0, ISU_MASK_OFFSET, rnd & ISU_STATUS_IMPL);
        bus_xfer(1'b1, ISU_MASK_OFFSET, 32'h1 << ISU_BIT_DP_DONE);
        strobe(5);
        repeat (2) @(posedge ref_clk);
        check("irq", 32'h0, {31'h0, irq});
        strobe(12);
        repeat (2) @(posedge ref_clk);
        check("irq", 32'h1, {31'h0, irq});
        bus_xfer(1'b1, ISU_STATUS_OFFSET, 32'h1 << ISU_BIT_DP_DONE);
        repeat (2) @(posedge ref_clk);
        check("irq", 32'h0, {31'h0, irq});
        bus_xfer(1'b0, ISU_STATUS_OFFSET, 32'h1 << ISU_BIT_TX_ERROR);
        // Receive writes pass, then are dropped during an overflow.
        rx_write_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("rx_write_en", 32'h1, {31'h0, rx_write_en});
        src[4] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("rx_write_en", 32'h0, {31'h0, rx_write_en});
        src[4] <= 1'b0;
        rx_write_req <= 1'b0;
        // An unmapped place ignores writes and reads as zero.
        rnd = xorshift(rnd);
        bus_xfer(1'b1, 12'h0f0, rnd);
        bus_xfer(1'b0, 12'h0f0, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        end_of_test();
    end

endmodule
